// ==== rtl/aspm_pkg.sv ====
// package: constants and carriers for the analog shared pad mux
package aspm_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned ASPM_NUM_PADS = 8;
    localparam int unsigned ASPM_SEL_W = 4;
    localparam int unsigned ASPM_NUM_SHARED = 4;
    // ------------------------------------------------------------
    // mux encodings
    // ------------------------------------------------------------
    localparam logic [3:0] ASPM_ENC_GPIO = 4'h0;
    localparam logic [3:0] ASPM_ENC_3 = 4'h3;
    localparam logic [3:0] ASPM_ENC_4 = 4'h4;
    localparam logic [3:0] ASPM_ENC_5 = 4'h5;
    localparam logic [3:0] ASPM_ENC_6 = 4'h6;
    localparam logic [3:0] ASPM_ENC_7 = 4'h7;
    localparam logic [3:0] ASPM_ENC_10 = 4'hA;
    localparam logic [3:0] ASPM_ENC_11 = 4'hB;
    localparam logic [3:0] ASPM_ENC_12 = 4'hC;
    localparam logic [3:0] ASPM_ENC_13 = 4'hD;
    // analog channel sits outside the digital encodings
    localparam logic [3:0] ASPM_ENC_ANALOG = 4'hF;
    localparam logic [3:0] ASPM_SEL_RESET = ASPM_ENC_GPIO;
    // ------------------------------------------------------------
    // low-power pad override modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASPM_LP_HIZ,
        ASPM_LP_PULLUP,
        ASPM_LP_PULLDN,
        ASPM_LP_DRIVE
    } aspm_lp_e;
    typedef enum logic [1:0] {
        ASPM_PWR_ACTIVE,
        ASPM_PWR_DEEP_SLEEP,
        ASPM_PWR_HIBERNATE
    } aspm_pwr_e;
    // per-pad low-power setting from software
    typedef struct packed {
        aspm_lp_e mode;
        logic level;
    } aspm_lp_cfg_s;
    // pad cell control
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_dn;
        logic analog_en;
    } aspm_pad_s;
    // peripheral outputs toward the pads
    typedef struct packed {
        logic [7:0] general_io_out;
        logic [7:0] general_io_oe;
        logic serial_port1_transmit;
        logic serial_port0_rts;
        logic serial_port0_transmit;
        logic serial_port1_rts;
        logic audio_serial_data_line;
        logic audio_serial_data_line_oe;
        logic audio_sdata0;
        logic audio_sdata0_oe;
        logic audio_clock;
        logic audio_frame_sync;
        logic pwm_out;
        logic sd_data0;
        logic sd_data0_oe;
    } aspm_periph_out_s;
    // pad inputs routed back to peripherals
    typedef struct packed {
        logic [7:0] general_io_in;
        logic serial_port0_receive;
        logic serial_port1_receive;
        logic serial_port0_cts;
        logic serial_port1_cts;
        logic timer_capture_input;
        logic timer_capture5;
        logic timer_capture6;
        logic timer_capture0;
        logic [3:0] camera_data_bit;
        logic audio_serial_data_line;
        logic audio_sdata0;
        logic sd_irq;
        logic sd_data0;
    } aspm_periph_in_s;
    // ------------------------------------------------------------
    // power-up strap and clock sensing
    // ------------------------------------------------------------
    localparam real ASPM_EXT_CLK_KHZ = 32.768;
    localparam int unsigned ASPM_SENSE_CYCLES = 16;
    localparam logic [4:0] ASPM_SENSE_LAST = 5'h10;
endpackage : aspm_pkg

// ==== rtl/aspm_pad_mux.sv ====
// module: analog shared pad mux with low-power and reset pad states
`timescale 1ns/1ps
module aspm_pad_mux (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic system_reset_low_i,
    input wire aspm_pkg::aspm_pwr_e pwr_state_i,
    input wire logic sel_we_i,
    input wire logic [2:0] sel_pad_i,
    input wire logic [3:0] sel_val_i,
    input wire aspm_pkg::aspm_lp_cfg_s [7:0] lp_cfg_i,
    input wire aspm_pkg::aspm_periph_out_s periph_out_i,
    output aspm_pkg::aspm_periph_in_s periph_in_o,
    input wire logic [7:0] pad_in_i,
    output aspm_pkg::aspm_pad_s [7:0] pad_o,
    input wire logic strap_oe_req_i,
    input wire logic strap_out_i,
    output aspm_pkg::aspm_pad_s strap_pad_o,
    input wire logic xtal_out_pad_i,
    input wire logic [1:0] antenna_select_i,
    output logic [1:0] antenna_select_o,
    output logic ext_clk_mode_o,
    output logic [31:0] pad_sel_o
);
    import aspm_pkg::*;

    // ------------------------------------------------------------
    // select storage
    // ------------------------------------------------------------
    logic [3:0] sel_q [ASPM_NUM_PADS];
    logic pad_pwrup_q;
    logic [4:0] sense_cnt_q;
    logic [2:0] xtal_sync_q;
    logic ext_clk_q;
    logic [2:0] in_sync_q [ASPM_NUM_PADS];
    logic [7:0] in_q;
    aspm_pad_s [7:0] pad_d;
    aspm_pad_s [7:0] pad_q;
    aspm_pad_s strap_q;
    aspm_periph_in_s pin_d;
    aspm_periph_in_s pin_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < ASPM_NUM_PADS; i++) begin
                sel_q[i] <= ASPM_SEL_RESET;
            end
        end else if (sel_we_i) begin
            sel_q[sel_pad_i] <= sel_val_i;
        end
    end

    // pad inputs: three flops, change taken when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < ASPM_NUM_PADS; i++) begin
                in_sync_q[i] <= 3'h0;
            end
            in_q <= 8'h00;
        end else begin
            for (int i = 0; i < ASPM_NUM_PADS; i++) begin
                in_sync_q[i] <= {in_sync_q[i][1:0], pad_in_i[i]};
                if (in_sync_q[i][1] == in_sync_q[i][2]) begin
                    in_q[i] <= in_sync_q[i][2];
                end
            end
        end
    end

    // sense pull-up on crystal output pad during a power-up window
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xtal_sync_q <= 3'h0;
            sense_cnt_q <= 5'h00;
            ext_clk_q <= 1'b0;
            pad_pwrup_q <= 1'b1;
        end else begin
            xtal_sync_q <= {xtal_sync_q[1:0], xtal_out_pad_i};
            if (sense_cnt_q != ASPM_SENSE_LAST) begin
                sense_cnt_q <= sense_cnt_q + 5'h01;
                if (xtal_sync_q[1] == xtal_sync_q[2]) begin
                    ext_clk_q <= xtal_sync_q[2];
                end
            end else begin
                pad_pwrup_q <= 1'b0;
            end
        end
    end
    assign ext_clk_mode_o = ext_clk_q;

    // ------------------------------------------------------------
    // per-pad routing
    // ------------------------------------------------------------
    always_comb begin
        pad_d = '0;
        pin_d = '0;
        for (int p = 0; p < ASPM_NUM_PADS; p++) begin
            pin_d.general_io_in[p] = (sel_q[p] == ASPM_ENC_GPIO) & in_q[p];
            if (sel_q[p] == ASPM_ENC_GPIO) begin
                pad_d[p].out = periph_out_i.general_io_out[p];
                pad_d[p].oe = periph_out_i.general_io_oe[p];
            // analog path on shared pads only
            end else if (sel_q[p] == ASPM_ENC_ANALOG && p < ASPM_NUM_SHARED) begin
                pad_d[p].analog_en = 1'b1;
            end
        end
        if (sel_q[0] == ASPM_ENC_3) pin_d.serial_port0_receive = in_q[0];
        if (sel_q[0] == ASPM_ENC_6) pin_d.serial_port1_receive = in_q[0];
        if (sel_q[0] == ASPM_ENC_7) pin_d.timer_capture_input = in_q[0];
        if (sel_q[1] == ASPM_ENC_6) begin
            pad_d[1].out = periph_out_i.serial_port1_transmit;
            pad_d[1].oe = 1'b1;
        end
        if (sel_q[1] == ASPM_ENC_4) pin_d.camera_data_bit[3] = in_q[1];
        if (sel_q[2] == ASPM_ENC_6) pin_d.serial_port1_receive = in_q[2];
        if (sel_q[2] == ASPM_ENC_4) pin_d.camera_data_bit[2] = in_q[2];
        if (sel_q[3] == ASPM_ENC_4) pin_d.camera_data_bit[1] = in_q[3];
        if (sel_q[3] == ASPM_ENC_6) begin
            pad_d[3].out = periph_out_i.audio_serial_data_line;
            pad_d[3].oe = periph_out_i.audio_serial_data_line_oe;
            pin_d.audio_serial_data_line = in_q[3];
        end
        if (sel_q[3] == ASPM_ENC_7) pin_d.timer_capture5 = in_q[3];
        // digital-only pads 4..7
        if (sel_q[4] == ASPM_ENC_5) begin
            pad_d[4].out = periph_out_i.serial_port0_rts;
            pad_d[4].oe = 1'b1;
        end
        if (sel_q[4] == ASPM_ENC_4) pin_d.camera_data_bit[0] = in_q[4];
        if (sel_q[4] == ASPM_ENC_3) pin_d.serial_port1_cts = in_q[4];
        if (sel_q[4] == ASPM_ENC_6) pin_d.serial_port0_cts = in_q[4];
        if (sel_q[4] == ASPM_ENC_7) pin_d.timer_capture6 = in_q[4];
        if (sel_q[5] == ASPM_ENC_13) begin
            pad_d[5].out = periph_out_i.audio_clock;
            pad_d[5].oe = 1'b1;
        end
        if (sel_q[5] == ASPM_ENC_3) begin
            pad_d[5].out = periph_out_i.serial_port1_rts;
            pad_d[5].oe = 1'b1;
        end
        if (sel_q[5] == ASPM_ENC_10) begin
            pad_d[5].out = periph_out_i.serial_port0_rts;
            pad_d[5].oe = 1'b1;
        end
        if (sel_q[5] == ASPM_ENC_11) begin
            pad_d[5].out = periph_out_i.serial_port0_transmit;
            pad_d[5].oe = 1'b1;
        end
        if (sel_q[6] == ASPM_ENC_6) pin_d.sd_irq = in_q[6];
        if (sel_q[6] == ASPM_ENC_7) begin
            pad_d[6].out = periph_out_i.audio_frame_sync;
            pad_d[6].oe = 1'b1;
        end
        if (sel_q[6] == ASPM_ENC_12) pin_d.timer_capture6 = in_q[6];
        if (sel_q[7] == ASPM_ENC_3) begin
            pad_d[7].out = periph_out_i.pwm_out;
            pad_d[7].oe = 1'b1;
        end
        if (sel_q[7] == ASPM_ENC_6) begin
            pad_d[7].out = periph_out_i.sd_data0;
            pad_d[7].oe = periph_out_i.sd_data0_oe;
            pin_d.sd_data0 = in_q[7];
        end
        if (sel_q[7] == ASPM_ENC_7) begin
            pad_d[7].out = periph_out_i.audio_sdata0;
            pad_d[7].oe = periph_out_i.audio_sdata0_oe;
            pin_d.audio_sdata0 = in_q[7];
        end
        if (sel_q[7] == ASPM_ENC_12) pin_d.timer_capture0 = in_q[7];
        // low-power states override every pad output control; input routing is kept
        for (int p = 0; p < ASPM_NUM_PADS; p++) begin
            // deep sleep / hibernate, software override per pad
            if (pwr_state_i != ASPM_PWR_ACTIVE) begin
                pad_d[p] = '0;
                pad_d[p].pull_up = lp_cfg_i[p].mode == ASPM_LP_PULLUP;
                pad_d[p].pull_dn = lp_cfg_i[p].mode == ASPM_LP_PULLDN;
                pad_d[p].oe = lp_cfg_i[p].mode == ASPM_LP_DRIVE;
                pad_d[p].out = lp_cfg_i[p].level;
            end
            if (!system_reset_low_i) begin
                pad_d[p] = '0;
            end
        end
    end

    // registered pad controls and peripheral inputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pad_q <= '0;
            pin_q <= '0;
        end else begin
            pad_q <= pad_d;
            pin_q <= pin_d;
        end
    end
    assign pad_o = pad_q;
    assign periph_in_o = pin_q;

    // strap pad drives high at power-up; hibernate pull-down
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            strap_q <= '{out: 1'b1, oe: 1'b1, default: 1'b0};
        end else if (pwr_state_i == ASPM_PWR_HIBERNATE) begin
            strap_q <= '{pull_dn: 1'b1, default: 1'b0};
        end else if (pad_pwrup_q) begin
            strap_q <= '{out: 1'b1, oe: 1'b1, default: 1'b0};
        end else begin
            // output functions only, never an input path
            strap_q <= '{out: strap_out_i, oe: strap_oe_req_i,
                         default: 1'b0};
        end
    end
    assign strap_pad_o = strap_q;

    // antenna selects are dedicated registered outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            antenna_select_o <= 2'h0;
        end else begin
            antenna_select_o <= antenna_select_i;
        end
    end

    // readback of the stored selects
    always_comb begin
        for (int i = 0; i < ASPM_NUM_PADS; i++) begin
            pad_sel_o[i*4 +: 4] = sel_q[i];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // one clock domain: shared clock and reset guard for every check
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    chk_reset_hiz: assert property (
        !system_reset_low_i |=> !pad_q[0].oe && !pad_q[7].oe)
        else $error("pad driven while system reset low");
    chk_default_sel: assert property (
        $fell(reset_i) |-> sel_q[0] == ASPM_ENC_GPIO)
        else $error("select not general io after reset");
    chk_strap_high: assert property (
        pad_pwrup_q && pwr_state_i != ASPM_PWR_HIBERNATE
        |=> strap_q.oe && strap_q.out)
        else $error("strap pad not driven high at power-up");
    chk_strap_hib: assert property (
        pwr_state_i == ASPM_PWR_HIBERNATE |=> !strap_q.oe && strap_q.pull_dn)
        else $error("strap pad not hi-z pulled down in hibernate");
    chk_lp_hiz: assert property (
        pwr_state_i != ASPM_PWR_ACTIVE && lp_cfg_i[0].mode == ASPM_LP_HIZ
        |=> !pad_q[0].oe && !pad_q[0].pull_up && !pad_q[0].pull_dn)
        else $error("low-power pad not hi-z");
    // analog code must open the converter path on a shared pad only
    chk_analog_path: assert property (
        sel_q[0] == ASPM_ENC_ANALOG && pwr_state_i == ASPM_PWR_ACTIVE
        && system_reset_low_i
        |=> pad_q[0].analog_en && !pad_q[4].analog_en)
        else $error("analog path wrong on shared or digital pad");
endmodule : aspm_pad_mux

// ==== dv/aspm_pad_mux_tb.sv ====
// testbench: self-checking bench for the analog shared pad mux
`timescale 1ns/1ps
module aspm_pad_mux_tb;
    import aspm_pkg::*;
    logic clk_i;
    logic reset_i;
    logic system_reset_low_i;
    aspm_pwr_e pwr_state_i;
    logic sel_we_i;
    logic [2:0] sel_pad_i;
    logic [3:0] sel_val_i;
    aspm_lp_cfg_s [7:0] lp_cfg_i;
    aspm_periph_out_s periph_out_i;
    aspm_periph_in_s periph_in_o;
    logic [7:0] pad_in_i;
    aspm_pad_s [7:0] pad_o;
    logic strap_oe_req_i;
    logic strap_out_i;
    aspm_pad_s strap_pad_o;
    logic xtal_out_pad_i;
    logic [1:0] antenna_select_i;
    logic [1:0] antenna_select_o;
    logic ext_clk_mode_o;
    logic [31:0] pad_sel_o;
    int n_errors;
    int num_checks;
    int cyc;
    // codes that pad 0 does not list
    localparam logic [3:0] BAD [4] = '{4'h1, 4'h4, 4'h8, 4'hE};
    // general io output pattern, one bit per pad
    localparam logic [7:0] GIO_PAT = 8'hA5;

    aspm_pad_mux u_aspm_pad_mux (
        .clk_i(clk_i), .reset_i(reset_i),
        .system_reset_low_i(system_reset_low_i),
        .pwr_state_i(pwr_state_i), .sel_we_i(sel_we_i),
        .sel_pad_i(sel_pad_i), .sel_val_i(sel_val_i),
        .lp_cfg_i(lp_cfg_i), .periph_out_i(periph_out_i),
        .periph_in_o(periph_in_o), .pad_in_i(pad_in_i), .pad_o(pad_o),
        .strap_oe_req_i(strap_oe_req_i), .strap_out_i(strap_out_i),
        .strap_pad_o(strap_pad_o), .xtal_out_pad_i(xtal_out_pad_i),
        .antenna_select_i(antenna_select_i),
        .antenna_select_o(antenna_select_o),
        .ext_clk_mode_o(ext_clk_mode_o), .pad_sel_o(pad_sel_o)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    // under two hundred cycles are expected; the ceiling leaves margin
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // one compare for every result; narrower values zero-extend
    task automatic chk(input string what, input logic [39:0] exp,
                       input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // let n edges pass, then look once their updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    // select write: taken at c0, stored select visible at c1
    task automatic wr_sel(input logic [2:0] pad, input logic [3:0] val);
        @(posedge clk_i);
        sel_we_i <= 1'h1;
        sel_pad_i <= pad;
        sel_val_i <= val;
        @(posedge clk_i);
        sel_we_i <= 1'h0;
        settle(1);
        chk("pad_sel", val, pad_sel_o[pad*4 +: 4]);
        settle(1);
    endtask : wr_sel

    task automatic do_reset(input logic xtal);
        @(posedge clk_i);
        reset_i <= 1'h1;
        xtal_out_pad_i <= xtal;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'h0;
        settle(1);
    endtask : do_reset

    function automatic logic [7:0] oes();
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = pad_o[i].oe;
        return r;
    endfunction : oes

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        reset_i = 1'h1;
        system_reset_low_i = 1'h1;
        pwr_state_i = ASPM_PWR_ACTIVE;
        sel_we_i = 1'h0;
        sel_pad_i = 3'h0;
        sel_val_i = 4'h0;
        lp_cfg_i = '0;
        periph_out_i = '0;
        pad_in_i = 8'h00;
        strap_oe_req_i = 1'h1;
        strap_out_i = 1'h0;
        xtal_out_pad_i = 1'h1;
        antenna_select_i = 2'h0;
        do_reset(1'h1);
        chk("pad_o", 40'h0, pad_o);
        chk("pad_sel", 32'h0, pad_sel_o);
        chk("strap", 2'h3, {strap_pad_o.out, strap_pad_o.oe});
        settle(20);
        chk("ext_clk", 1'h1, ext_clk_mode_o);
        chk("strap", 2'h1, {strap_pad_o.out, strap_pad_o.oe});
        // general io on every pad by default, both directions
        @(posedge clk_i);
        periph_out_i.general_io_oe <= 8'hFF;
        periph_out_i.general_io_out <= GIO_PAT;
        pad_in_i <= 8'h3C;
        settle(8);
        for (int i = 0; i < 8; i++) begin
            chk("gio_out", {1'h1, GIO_PAT[i]},
                {pad_o[i].oe, pad_o[i].out});
        end
        chk("gio_in", 8'h3C, periph_in_o.general_io_in);
        // second serial port transmit on pad 1
        wr_sel(3'h1, ASPM_ENC_6);
        chk("tx_pad", 2'h2, {pad_o[1].oe, pad_o[1].out});
        @(posedge clk_i);
        periph_out_i.serial_port1_transmit <= 1'h1;
        settle(3);
        chk("tx_pad", 2'h3, {pad_o[1].oe, pad_o[1].out});
        // receive on pad 0 and camera bit on pad 2, back to back
        wr_sel(3'h0, ASPM_ENC_6);
        wr_sel(3'h2, ASPM_ENC_4);
        chk("rx_oe", 2'h0, {pad_o[0].oe, pad_o[2].oe});
        @(posedge clk_i);
        pad_in_i <= 8'h05;
        settle(8);
        chk("rx_in", 1'h1, periph_in_o.serial_port1_receive);
        chk("cam_in", 1'h1, |periph_in_o.camera_data_bit);
        @(posedge clk_i);
        pad_in_i <= 8'h00;
        settle(8);
        chk("rx_in", 1'h0, periph_in_o.serial_port1_receive);
        chk("cam_in", 1'h0, |periph_in_o.camera_data_bit);
        // unlisted codes leave the pad floating
        foreach (BAD[k]) begin
            wr_sel(3'h0, BAD[k]);
            chk("bad_pad", 2'h0, {pad_o[0].oe, pad_o[0].analog_en});
        end
        wr_sel(3'h0, ASPM_ENC_ANALOG);
        chk("analog", 2'h1, {pad_o[0].oe, pad_o[0].analog_en});
        wr_sel(3'h4, ASPM_ENC_ANALOG);
        chk("dig_ana", 2'h0, {pad_o[4].oe, pad_o[4].analog_en});
        settle(2);
        chk("oes", 8'hEA, oes());
        // antenna selects follow their inputs one clock later
        @(posedge clk_i);
        antenna_select_i <= 2'h2;
        settle(2);
        chk("antsel", 2'h2, antenna_select_o);
        @(posedge clk_i);
        antenna_select_i <= 2'h1;
        settle(2);
        chk("antsel", 2'h1, antenna_select_o);
        // deep sleep: every override mode on pad 5
        @(posedge clk_i);
        pwr_state_i <= ASPM_PWR_DEEP_SLEEP;
        lp_cfg_i[7] <= '{mode: ASPM_LP_PULLDN, level: 1'h0};
        settle(3);
        chk("ds_oes", 8'h00, oes());
        chk("ds_pulldn", 1'h1, pad_o[7].pull_dn);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            lp_cfg_i[5] <= '{mode: aspm_lp_e'(m), level: 1'h0};
            settle(3);
            chk("ds_pad", {m == 3, m == 1, m == 2, 1'h0},
                {pad_o[5].oe, pad_o[5].pull_up, pad_o[5].pull_dn,
                 pad_o[5].out});
        end
        // hibernate: one driven pad, strap pulled down
        @(posedge clk_i);
        pwr_state_i <= ASPM_PWR_HIBERNATE;
        lp_cfg_i[5] <= '{mode: ASPM_LP_HIZ, level: 1'h0};
        lp_cfg_i[6] <= '{mode: ASPM_LP_DRIVE, level: 1'h1};
        settle(3);
        chk("hib_oes", 8'h40, oes());
        chk("hib_out", 1'h1, pad_o[6].out);
        chk("hib_strap", 2'h1, {strap_pad_o.oe, strap_pad_o.pull_dn});
        // system reset low beats the low-power drive
        @(posedge clk_i);
        system_reset_low_i <= 1'h0;
        settle(2);
        chk("rst_oes", 8'h00, oes());
        @(posedge clk_i);
        pwr_state_i <= ASPM_PWR_ACTIVE;
        settle(2);
        chk("rst_oes", 8'h00, oes());
        @(posedge clk_i);
        system_reset_low_i <= 1'h1;
        settle(3);
        chk("oes", 8'hEA, oes());
        // more listed routes: receive, handshake in, transmit, pwm
        wr_sel(3'h0, ASPM_ENC_3);
        wr_sel(3'h4, ASPM_ENC_6);
        wr_sel(3'h5, ASPM_ENC_11);
        wr_sel(3'h7, ASPM_ENC_3);
        @(posedge clk_i);
        periph_out_i.serial_port0_transmit <= 1'h1;
        periph_out_i.pwm_out <= 1'h1;
        pad_in_i <= 8'h11;
        settle(8);
        chk("rx0_in", 1'h1, periph_in_o.serial_port0_receive);
        chk("cts0_in", 1'h1, periph_in_o.serial_port0_cts);
        chk("tx0_pad", 2'h3, {pad_o[5].oe, pad_o[5].out});
        chk("pwm_pad", 2'h3, {pad_o[7].oe, pad_o[7].out});
        // second reset with no pull-up on the crystal pad
        do_reset(1'h0);
        chk("pad_sel", 32'h0, pad_sel_o);
        chk("strap", 2'h3, {strap_pad_o.out, strap_pad_o.oe});
        settle(20);
        chk("ext_clk", 1'h0, ext_clk_mode_o);
        results();
    end
endmodule : aspm_pad_mux_tb
